/* sre_pkg.sv */
// How it works
// - Addressing byte with direction bit one requests read data from the device.
// - Word-address counter holds last accessed location plus one, kept between transactions.
// - Counter wraps from the last array byte to the first byte.
// - After acknowledging a read addressing byte, shift out the byte at the counter.
// - Controller acknowledging each data byte turns any read into a sequential read.
// - On each zero acknowledge, advance the counter and send the next byte.
// - Sequential read passing the top location wraps to zero and keeps going.
// - Read ends on a withheld acknowledge and stop; device stops driving data.
// - Bytes are eight bits; device pulls data low in the ninth clock to acknowledge.
// - Select bits of the addressing byte must equal the three select inputs.
// - A mismatching addressing byte is not acknowledged; rest of transaction is ignored.
// - Dummy write carries two word-address bytes, each acknowledged by the device.
package sre_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int SRE_ADDR_W = 15;
  localparam int SRE_MEM_DEPTH = 32768;
  localparam int SRE_BYTE_W = 8;
  localparam int SRE_STAT_W = 16;

  // Addressing byte fixed code in its top four bits
  localparam logic [3:0] SRE_DEV_CODE = 4'ha;

  // Bit counter value of the acknowledge slot
  localparam logic [3:0] SRE_ACK_SLOT = 4'h8;
  localparam logic [3:0] SRE_BIT_FIRST = 4'h0;

  // Reset values
  localparam logic [SRE_ADDR_W-1:0] SRE_ADDR_RST = 15'h0000;
  localparam logic [SRE_STAT_W-1:0] SRE_STAT_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Link states, gray along addressing -> word address -> read
  typedef enum logic [2:0] {
    SRE_IDLE = 3'b000,
    SRE_DEV  = 3'b001,
    SRE_AHI  = 3'b011,
    SRE_ALO  = 3'b010,
    SRE_READ = 3'b110
  } sre_state_e;

  // Array preload word
  typedef struct packed {
    logic [SRE_ADDR_W-1:0] addr;
    logic [SRE_BYTE_W-1:0] data;
  } sre_load_s;

  // Serial pins as seen by the design
  typedef struct packed {
    logic sda_in;
    logic [2:0] chip_select;
  } sre_pins_s;

endpackage

/* sre_tsync.sv */
`timescale 1ns/10ps
// Toggle crossing: two flops, then an edge detector on the second
module sre_tsync
(
  input wire logic clk,      // Destination clock
  input wire logic rst_n,    // Async reset, active low
  input wire logic tgl_in,   // Toggle from the other domain
  output logic pulse         // One-cycle event in this domain
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // Two-flop synchroniser and edge memory
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      meta_r <= tgl_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Edge of the synchronised toggle
  assign pulse = sync_r ^ last_r;

endmodule

/* sre_read_engine.sv */
`timescale 1ns/10ps
module sre_read_engine
(
  input wire logic sys_clk,                  // System clock, 10 MHz
  input wire logic rst_n,                    // Async reset, active low
  input wire logic scl_clk,                  // Link clock from controller
  input wire logic sda_i,                    // Resolved data line level
  output logic sda_o,                        // Data line drive value, always 0
  output logic sda_oe,                       // Pull data line low when high
  input wire logic chip_select_in_2,         // Hardwired select input 2
  input wire logic chip_select_in_1,         // Hardwired select input 1
  input wire logic chip_select_in_0,         // Hardwired select input 0
  input wire logic load_en,                  // Request an array preload
  input wire sre_pkg::sre_load_s load_word,  // Preload address and data
  output logic load_busy,                    // Preload in progress
  output logic [sre_pkg::SRE_STAT_W-1:0] bytes_read // Bytes shifted out
);

  import sre_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain state
  logic [SRE_BYTE_W-1:0] mem [SRE_MEM_DEPTH];
  sre_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [SRE_BYTE_W-1:0] shift_r;
  logic [SRE_ADDR_W-1:0] addr_cnt_r;
  logic [6:0] addr_hi_r;
  logic start_tgl_r;
  logic start_seen_r;
  logic stop_tgl_r;
  logic stop_seen_r;
  logic rd_tgl_r;
  logic ld_ack_tgl_r;
  logic oe_r;
  sre_pins_s pins;
  logic [SRE_BYTE_W-1:0] rd_byte;
  logic sel_match;
  logic [2:0] cs_meta_r;
  logic [2:0] cs_sync_r;
  logic drv_val_r;

  // System domain state
  logic ld_req_tgl_r;
  sre_load_s ld_hold_r;
  logic busy_r;
  logic [SRE_STAT_W-1:0] count_r;
  logic ld_req_pulse;
  logic ld_ack_pulse;
  logic rd_pulse;

  assign pins = '{sda_in: sda_i,
                  chip_select: {chip_select_in_2, chip_select_in_1, chip_select_in_0}};

  // Addressing byte decode on the byte just received
  function automatic logic dev_hit(input logic [SRE_BYTE_W-1:0] b, input logic [2:0] cs);
    dev_hit = (b[7:4] == SRE_DEV_CODE) && (b[3:1] == cs);
  endfunction

  assign sel_match = dev_hit(shift_r, cs_sync_r);
  assign rd_byte = mem[addr_cnt_r];

  // Select pins pass two flops in the link domain before the compare
  always_ff @(posedge scl_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_meta_r <= '0;
      cs_sync_r <= '0;
    end
    else
    begin
      cs_meta_r <= pins.chip_select;
      cs_sync_r <= cs_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start detector: data falls while clock high
  always_ff @(negedge sda_i or negedge rst_n)
  begin
    if (!rst_n)
      start_tgl_r <= 1'b0;
    else if (scl_clk)
      start_tgl_r <= ~start_tgl_r;
  end

  // Stop detector: data rises while clock high
  always_ff @(posedge sda_i or negedge rst_n)
  begin
    if (!rst_n)
      stop_tgl_r <= 1'b0;
    else if (scl_clk)
      stop_tgl_r <= ~stop_tgl_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit sequencer on the rising link clock edge
  always_ff @(posedge scl_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= SRE_IDLE;
      bit_cnt_r <= SRE_BIT_FIRST;
      shift_r <= '0;
      start_seen_r <= 1'b0;
      stop_seen_r <= 1'b0;
      addr_hi_r <= '0;
      addr_cnt_r <= SRE_ADDR_RST;
      rd_tgl_r <= 1'b0;
    end
    else if (start_tgl_r != start_seen_r)
    begin
      // First bit after a start or repeated start
      start_seen_r <= start_tgl_r;
      stop_seen_r <= stop_tgl_r;
      state_r <= SRE_DEV;
      shift_r <= {7'h00, pins.sda_in};
      bit_cnt_r <= 4'h1;
    end
    else if (stop_tgl_r != stop_seen_r)
    begin
      // Stop parks the link in standby
      stop_seen_r <= stop_tgl_r;
      state_r <= SRE_IDLE;
      bit_cnt_r <= SRE_BIT_FIRST;
    end
    else if (state_r != SRE_IDLE && bit_cnt_r != SRE_ACK_SLOT)
    begin
      // Eight data bits per byte
      shift_r <= {shift_r[6:0], pins.sda_in};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
    else if (state_r != SRE_IDLE)
    begin
      // Acknowledge slot closes the byte
      bit_cnt_r <= SRE_BIT_FIRST;
      case (state_r)
        SRE_DEV:
        begin
          if (!sel_match)
            state_r <= SRE_IDLE;
          else if (shift_r[0])
            state_r <= SRE_READ;
          else
            state_r <= SRE_AHI;
        end
        SRE_AHI:
        begin
          addr_hi_r <= shift_r[6:0];
          state_r <= SRE_ALO;
        end
        SRE_ALO:
        begin
          addr_cnt_r <= {addr_hi_r, shift_r};
          state_r <= SRE_IDLE;
        end
        SRE_READ:
        begin
          addr_cnt_r <= addr_cnt_r + 15'h0001;
          rd_tgl_r <= ~rd_tgl_r;
          if (pins.sda_in)
            state_r <= SRE_IDLE;
          else
            state_r <= SRE_READ;
        end
        default:
          state_r <= SRE_IDLE;
      endcase
    end
  end

  // Data line drive, updated only on the falling clock edge
  always_ff @(negedge scl_clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_r <= 1'b0;
    else if (bit_cnt_r == SRE_ACK_SLOT)
      oe_r <= (state_r == SRE_DEV && sel_match) || state_r == SRE_AHI
              || state_r == SRE_ALO;
    else if (state_r == SRE_READ)
      oe_r <= ~rd_byte[3'd7 - bit_cnt_r[2:0]];
    else
      oe_r <= 1'b0;
  end

  // Open-drain drive value, held low so the pin only ever pulls down
  always_ff @(negedge scl_clk or negedge rst_n)
  begin
    if (!rst_n)
      drv_val_r <= 1'b0;
    else
      drv_val_r <= 1'b0;
  end

  assign sda_oe = oe_r;
  assign sda_o = drv_val_r;

  ////////////////////////////////////////////////////////////////////////////
  // Preload write into the array, held word crosses by handshake
  always_ff @(posedge scl_clk or negedge rst_n)
  begin
    if (!rst_n)
      ld_ack_tgl_r <= 1'b0;
    else if (ld_req_pulse)
      ld_ack_tgl_r <= ~ld_ack_tgl_r;
  end

  // Array storage, no reset
  always_ff @(posedge scl_clk)
  begin
    if (ld_req_pulse)
      mem[ld_hold_r.addr] <= ld_hold_r.data;
  end

  sre_tsync u_ld_req
  (
    .clk(scl_clk),
    .rst_n(rst_n),
    .tgl_in(ld_req_tgl_r),
    .pulse(ld_req_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // System side of the preload handshake
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ld_req_tgl_r <= 1'b0;
      ld_hold_r <= '0;
      busy_r <= 1'b0;
    end
    else if (load_en && !busy_r)
    begin
      ld_hold_r <= load_word;
      ld_req_tgl_r <= ~ld_req_tgl_r;
      busy_r <= 1'b1;
    end
    else if (ld_ack_pulse)
      busy_r <= 1'b0;
  end

  // Count of bytes shifted out
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= SRE_STAT_RST;
    else if (rd_pulse)
      count_r <= count_r + 16'h0001;
  end

  assign load_busy = busy_r;
  assign bytes_read = count_r;

  sre_tsync u_ld_ack
  (
    .clk(sys_clk),
    .rst_n(rst_n),
    .tgl_in(ld_ack_tgl_r),
    .pulse(ld_ack_pulse)
  );

  sre_tsync u_rd_evt
  (
    .clk(sys_clk),
    .rst_n(rst_n),
    .tgl_in(rd_tgl_r),
    .pulse(rd_pulse)
  );

endmodule

/* sre_read_monitor.sv */
`timescale 1ns/10ps
// Checks link drive and preload handshake
module sre_read_monitor
(
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic scl_clk, // Link clock
  input wire logic sda_i, // Line level
  input wire logic sda_o, // Drive value
  input wire logic sda_oe, // Drive enable
  input wire logic load_en, // Load request
  input wire logic load_busy, // Load busy
  input wire logic [sre_pkg::SRE_STAT_W-1:0] bytes_read // Byte count
);
  import sre_pkg::*;
  logic oe_rise_r;
  // Enable seen at each rising link edge
  always_ff @(posedge scl_clk or negedge rst_n)
    if (!rst_n)
      oe_rise_r <= 1'b0;
    else
      oe_rise_r <= sda_oe;
  // Minimum busy span
  sequence busy_s;
    load_busy [*3];
  endsequence
  //////////////////////////////////////
  oe_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n) sda_oe |-> !sda_o)
    else $error("drive value not low");
  line_low_a: assert property (@(posedge scl_clk) disable iff (!rst_n) sda_oe |-> !sda_i)
    else $error("line not low while driven");
  oe_steady_a: assert property (@(negedge scl_clk) disable iff (!rst_n) sda_oe == oe_rise_r)
    else $error("drive changed while clock high");
  count_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(bytes_read) |-> bytes_read == $past(bytes_read) + 1'b1)
    else $error("byte count jumped");
  reset_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> bytes_read == '0 && !sda_oe && !load_busy)
    else $error("outputs not cleared by reset");
  busy_take_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    load_en && !load_busy |=> load_busy)
    else $error("load not taken");
  busy_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(load_busy) |-> busy_s)
    else $error("busy too short");
  busy_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(load_busy) |-> ##[1:200] !load_busy)
    else $error("busy never ends");
endmodule
bind sre_read_engine sre_read_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .load_en(load_en), .load_busy(load_busy), .bytes_read(bytes_read));

/* sre_ctrl_model.sv */
`timescale 1ns/10ps
// Bus controller; clock stands high between frames
module sre_ctrl_model
(
  output logic scl, // Link clock
  output logic sda_lo, // Pulls line low
  input wire logic sda // Resolved line
);
  // Idle bus
  initial
  begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  // One bit: set while low, read at the rise
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #12 sda_lo = !b;
    #12 scl = 1'b1;
    r = sda;
    #24;
  endtask
  // Start or repeated start
  task automatic start;
    scl = 1'b0;
    #12 sda_lo = 1'b0;
    #12 scl = 1'b1;
    #12 sda_lo = 1'b1;
    #12;
  endtask
  // Stop, line released after
  task automatic stop;
    scl = 1'b0;
    #12 sda_lo = 1'b1;
    #12 scl = 1'b1;
    #12 sda_lo = 1'b0;
    #12;
  endtask
  // Eight bits then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
    output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, ao);
  endtask
  // Free clocks with no frame, for preload
  task automatic pump;
    repeat (4)
    begin
      scl = 1'b0;
      #24 scl = 1'b1;
      #24;
    end
  endtask
endmodule

/* sre_read_engine_tb.sv */
`timescale 1ns/10ps
`define CHK(a, e) \
  total_checks++; \
  if ((a) !== (e)) \
  begin \
    failures++; \
    $display("Error %0t: got %h want %h", $time, a, e); \
  end
module sre_read_engine_tb;
  import sre_pkg::*;
  localparam logic [14:0] adr_tbl [4] = '{15'h7fff, 15'h0000, 15'h0001, 15'h0002};
  localparam logic [7:0] dat_tbl [4] = '{8'hc3, 8'h3c, 8'ha5, 8'h5a};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic load_en = 1'b0;
  sre_load_s load_word = '0;
  logic [2:0] cs = 3'h5;
  logic scl, sda_lo, sda_oe, sda_o, load_busy, ack;
  logic [SRE_STAT_W-1:0] bytes_read, base;
  logic [7:0] q;
  int failures = 0;
  int total_checks = 0;
  wire sda = !(sda_oe || sda_lo);
  always #50 sys_clk = !sys_clk;
  sre_read_engine u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_clk(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_in_2(cs[2]), .chip_select_in_1(cs[1]),
    .chip_select_in_0(cs[0]), .load_en(load_en), .load_word(load_word),
    .load_busy(load_busy), .bytes_read(bytes_read));
  sre_ctrl_model u_ctl (.scl(scl), .sda_lo(sda_lo), .sda(sda));
  //////////////////////////////////////
  // Verdict and end of run
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Preload one array byte
  task automatic load(input int i);
    @(posedge sys_clk);
    #1 load_en = 1'b1;
    load_word = '{addr: adr_tbl[i], data: dat_tbl[i]};
    @(posedge sys_clk);
    #1 load_en = 1'b0;
    `CHK(load_busy, 1'b1)
    for (int n = 0; n < 20 && load_busy; n++)
      u_ctl.pump;
    `CHK(load_busy, 1'b0)
  endtask
  // Dummy write to the top, then read across the wrap
  task automatic seq_wrap;
    base = bytes_read;
    u_ctl.start;
    u_ctl.xfer({SRE_DEV_CODE, cs, 1'b0}, 1'b1, q, ack);
    `CHK(ack, 1'b0)
    u_ctl.xfer(8'hff, 1'b1, q, ack);
    `CHK(ack, 1'b0)
    u_ctl.xfer(8'hff, 1'b1, q, ack);
    `CHK(ack, 1'b0)
    u_ctl.start;
    u_ctl.xfer({SRE_DEV_CODE, cs, 1'b1}, 1'b1, q, ack);
    `CHK(ack, 1'b0)
    for (int i = 0; i < 3; i++)
    begin
      u_ctl.xfer(8'hff, i == 2, q, ack);
      `CHK(q, dat_tbl[i])
    end
    u_ctl.stop;
    `CHK(sda_oe, 1'b0)
    repeat (6) @(posedge sys_clk);
    `CHK(bytes_read, base + 16'h0003)
  endtask
  // Wrong code or select: no acknowledge, line left high
  task automatic bad_addr;
    for (int i = 0; i < 2; i++)
    begin
      u_ctl.start;
      u_ctl.xfer(i ? {SRE_DEV_CODE, ~cs, 1'b1} : 8'h5b, 1'b1, q, ack);
      `CHK(ack, 1'b1)
      u_ctl.xfer(8'hff, 1'b1, q, ack);
      `CHK(q, 8'hff)
      u_ctl.stop;
    end
  endtask
  // Current read resumes after the last byte
  task automatic cur_read;
    u_ctl.start;
    u_ctl.xfer({SRE_DEV_CODE, cs, 1'b1}, 1'b1, q, ack);
    u_ctl.xfer(8'hff, 1'b1, q, ack);
    `CHK(q, dat_tbl[3])
    u_ctl.stop;
  endtask
  // Main sequence
  initial
  begin
    // Link clock runs during reset so the link-side flops clear too
    fork
      u_ctl.pump;
    join_none
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 4; i++)
      load(i);
    seq_wrap;
    bad_addr;
    cur_read;
    results;
  end
  // Watchdog
  initial
  begin
    #400000;
    failures++;
    results;
  end
endmodule
